// >>> include/sadc_defines.vh
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// Register byte offsets
`define SADC_OFF_CTRL     4'h0
`define SADC_OFF_STATUS   4'h4
`define SADC_OFF_CONFIG   4'h8
`define SADC_OFF_COUNT    4'hc

// Control and status fields
`define SADC_CTRL_EN_BIT  0
`define SADC_CTRL_RST     1'h1
`define SADC_ST_BUSY_BIT  16
`define SADC_ST_FRAME_BIT 17
`define SADC_ST_SMPL_BIT  18
`define SADC_ST_VALID_BIT 19

// Configuration word fields, first bit shifted in is bit 7
`define SADC_CFG_SGL_BIT  7
`define SADC_CFG_CH_HI    6
`define SADC_CFG_CH_LO    4
`define SADC_CFG_ODD_BIT  4
`define SADC_CFG_UNI_BIT  3
`define SADC_CFG_MSBF_BIT 2
`define SADC_CFG_WL_HI    1
`define SADC_CFG_WL_LO    0
`define SADC_CFG_BITS     4'h8
`define SADC_CFG_RST      8'h00

// Result coding
`define SADC_BIP_FLIP     10'h200
`define SADC_FULL_SCALE   10'h3ff
`define SADC_SAR_MSB      10'h200

// Timing counts
`define SADC_CONV_ACLK    6'h2c
`define SADC_SETUP_ACLK   2'h2
`define SADC_SMPL_OPEN    4'h4
`define SADC_SMPL_SCLK    3'h5

`endif

// >>> rtl/sadc_sar.v
`include "sadc_defines.vh"
`default_nettype none

module sadc_sar (
	input  wire       ref_clk_i,
	input  wire       reset_n_i,
	input  wire       aclk_fall_i,
	input  wire       start_i,
	input  wire [9:0] target_i,
	output reg        busy_o,
	output reg        done_o,
	output reg  [9:0] code_o
);

	reg  [5:0] cnt_r;
	reg  [9:0] bit_r;
	wire [9:0] trial_w;

	assign trial_w = code_o | bit_r;

	// One decision per converter clock for the first ten clocks, finished after the full count of 44
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			code_o <= 10'h000;
			cnt_r  <= 6'h00;
			bit_r  <= 10'h000;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				busy_o <= 1'b1;
				cnt_r  <= 6'h00;
				code_o <= 10'h000;
				bit_r  <= `SADC_SAR_MSB;
			end else if (busy_o && aclk_fall_i) begin
				cnt_r <= cnt_r + 6'h01;
				if (bit_r != 10'h000) begin
					if (trial_w <= target_i) begin
						code_o <= trial_w;
					end
					bit_r <= bit_r >> 1;
				end
				if (cnt_r == `SADC_CONV_ACLK - 6'h01) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// >>> rtl/sadc_top.v
`include "sadc_defines.vh"
`default_nettype none

module sadc_top (
	input  wire        ref_clk_i,
	input  wire        reset_n_i,
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	input  wire        cs_n_i,
	input  wire        sclk_i,
	input  wire        din_i,
	input  wire        aclk_i,
	input  wire [79:0] ain_i,
	output reg         dout_o,
	output reg         dout_oe_o,
	output reg         sampling_o
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ARM  = 2'h1;
	localparam [1:0] ST_XFER = 2'h2;
	localparam [3:0] SYNC_RST = 4'h1;

	// Input synchronisers
	wire [3:0] async_w;
	wire [3:0] sync_w;

	assign async_w = {aclk_i, din_i, sclk_i, cs_n_i};

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			reg meta_r;
			reg stab_r;
			always @(posedge ref_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					meta_r <= SYNC_RST[g];
					stab_r <= SYNC_RST[g];
				end else begin
					meta_r <= async_w[g];
					stab_r <= meta_r;
				end
			end
			assign sync_w[g] = stab_r;
		end
	endgenerate

	wire cs_n_s;
	wire sclk_s;
	wire din_s;
	wire aclk_s;

	assign cs_n_s = sync_w[0];
	assign sclk_s = sync_w[1];
	assign din_s  = sync_w[2];
	assign aclk_s = sync_w[3];

	reg sclk_d_r;
	reg aclk_d_r;

	wire sclk_rise;
	wire sclk_fall;
	wire aclk_fall;

	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign sclk_fall = ~sclk_s & sclk_d_r;
	assign aclk_fall = ~aclk_s & aclk_d_r;

	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_d_r <= 1'b0;
			aclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
			aclk_d_r <= aclk_s;
		end
	end

	// Helpers
	function [9:0] chan_val;
		input [79:0] ain;
		input [2:0]  idx;
		begin
			chan_val = ain[idx * 10 +: 10];
		end
	endfunction

	function [4:0] word_len;
		input [1:0] code;
		begin
			case (code)
				2'h0: word_len = 5'h08;
				2'h1: word_len = 5'h0a;
				2'h2: word_len = 5'h0c;
				default: word_len = 5'h10;
			endcase
		end
	endfunction

	function [9:0] bit_rev;
		input [9:0] v;
		integer k;
		begin
			for (k = 0; k < 10; k = k + 1) begin
				bit_rev[k] = v[9 - k];
			end
		end
	endfunction

	// Registers and state
	reg [1:0]  state_r;
	reg [1:0]  arm_cnt_r;
	reg [3:0]  in_cnt_r;
	reg [7:0]  cfg_sh_r;
	reg [7:0]  cfg_last_r;
	reg [7:0]  conv_cfg_r;
	reg [2:0]  smp_cnt_r;
	reg        smp_taken_r;
	reg [9:0]  target_r;
	reg        conv_start_r;
	reg [15:0] out_sh_r;
	reg [4:0]  out_left_r;
	reg [15:0] fmt_r;
	reg [4:0]  fmt_len_r;
	reg [9:0]  result_r;
	reg        valid_r;
	reg        ctrl_en_r;
	reg [15:0] conv_count_r;

	wire       conv_busy;
	wire       conv_done;
	wire [9:0] conv_code;

	// Input selection and clamping
	wire [2:0]  sel_pos;
	wire [2:0]  sel_neg;
	wire [10:0] pos_val;
	wire [10:0] neg_val;
	wire [11:0] diff_w;
	reg  [9:0]  target_nxt;

	assign sel_pos = cfg_sh_r[`SADC_CFG_SGL_BIT] ?
		cfg_sh_r[`SADC_CFG_CH_HI:`SADC_CFG_CH_LO] :
		{cfg_sh_r[6:5], cfg_sh_r[`SADC_CFG_ODD_BIT]};
	assign sel_neg = {cfg_sh_r[6:5], ~cfg_sh_r[`SADC_CFG_ODD_BIT]};
	assign pos_val = {1'b0, chan_val(ain_i, sel_pos)};
	assign neg_val = cfg_sh_r[`SADC_CFG_SGL_BIT] ? 11'h000 :
		{1'b0, chan_val(ain_i, sel_neg)};
	assign diff_w  = {pos_val[10], pos_val} - {neg_val[10], neg_val};

	always @* begin
		target_nxt = 10'h000;
		if (cfg_sh_r[`SADC_CFG_UNI_BIT]) begin
			if (diff_w[11]) begin
				target_nxt = 10'h000;
			end else begin
				target_nxt = diff_w[9:0];
			end
		end else begin
			if (!diff_w[11] && diff_w[10:9] != 2'h0) begin
				target_nxt = `SADC_FULL_SCALE;
			end else if (diff_w[11] && diff_w[10:9] != 2'h3) begin
				target_nxt = 10'h000;
			end else begin
				target_nxt = diff_w[9:0] ^ `SADC_BIP_FLIP;
			end
		end
	end

	// Output word formatting
	wire [9:0] res_code;
	wire [9:0] res_order;

	assign res_code  = conv_cfg_r[`SADC_CFG_UNI_BIT] ? conv_code :
		conv_code ^ `SADC_BIP_FLIP;
	assign res_order = conv_cfg_r[`SADC_CFG_MSBF_BIT] ? res_code :
		bit_rev(res_code);

	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fmt_r        <= 16'h0000;
			fmt_len_r    <= 5'h08;
			result_r     <= 10'h000;
			valid_r      <= 1'b0;
			conv_count_r <= 16'h0000;
		end else if (conv_done) begin
			fmt_r        <= {res_order, 6'h00};
			fmt_len_r    <= word_len(conv_cfg_r[1:0]);
			result_r     <= res_code;
			valid_r      <= 1'b1;
			conv_count_r <= conv_count_r + 16'h0001;
		end
	end

	// Frame sequencer
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r      <= ST_IDLE;
			arm_cnt_r    <= 2'h0;
			in_cnt_r     <= 4'h0;
			cfg_sh_r     <= `SADC_CFG_RST;
			cfg_last_r   <= `SADC_CFG_RST;
			conv_cfg_r   <= `SADC_CFG_RST;
			smp_cnt_r    <= 3'h0;
			smp_taken_r  <= 1'b0;
			target_r     <= 10'h000;
			conv_start_r <= 1'b0;
			out_sh_r     <= 16'h0000;
			out_left_r   <= 5'h00;
			dout_o       <= 1'b0;
			dout_oe_o    <= 1'b0;
			sampling_o   <= 1'b0;
		end else begin
			conv_start_r <= 1'b0;
			if (cs_n_s) begin
				dout_oe_o  <= 1'b0;
				dout_o     <= 1'b0;
				sampling_o <= 1'b0;
				if (state_r == ST_XFER && smp_taken_r) begin
					conv_start_r <= 1'b1;
					conv_cfg_r   <= cfg_sh_r;
					cfg_last_r   <= cfg_sh_r;
				end
				state_r <= ST_IDLE;
			end else begin
				case (state_r)
				ST_IDLE: begin
					if (ctrl_en_r) begin
						state_r   <= ST_ARM;
						arm_cnt_r <= 2'h0;
					end
				end
				ST_ARM: begin
					if (aclk_fall && !conv_busy) begin
						arm_cnt_r <= arm_cnt_r + 2'h1;
						if (arm_cnt_r == `SADC_SETUP_ACLK - 2'h1) begin
							state_r     <= ST_XFER;
							dout_oe_o   <= 1'b1;
							dout_o      <= fmt_r[15];
							out_sh_r    <= fmt_r;
							out_left_r  <= fmt_len_r - 5'h01;
							in_cnt_r    <= 4'h0;
							smp_cnt_r   <= 3'h0;
							smp_taken_r <= 1'b0;
						end
					end
				end
				ST_XFER: begin
					if (sclk_rise && in_cnt_r != `SADC_CFG_BITS) begin
						cfg_sh_r <= {cfg_sh_r[6:0], din_s};
						in_cnt_r <= in_cnt_r + 4'h1;
					end
					if (sclk_fall) begin
						if (out_left_r != 5'h00) begin
							out_sh_r   <= {out_sh_r[14:0], 1'b0};
							dout_o     <= out_sh_r[14];
							out_left_r <= out_left_r - 5'h01;
						end else begin
							dout_o <= 1'b0;
						end
						if (sampling_o) begin
							smp_cnt_r <= smp_cnt_r + 3'h1;
							if (smp_cnt_r == `SADC_SMPL_SCLK - 3'h1) begin
								sampling_o  <= 1'b0;
								smp_taken_r <= 1'b1;
								target_r    <= target_nxt;
							end
						end else if (!smp_taken_r &&
							in_cnt_r >= `SADC_SMPL_OPEN) begin
							sampling_o <= 1'b1;
							smp_cnt_r  <= 3'h0;
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
				endcase
			end
		end
	end

	sadc_sar u_sar (
		.ref_clk_i   (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.aclk_fall_i (aclk_fall),
		.start_i     (conv_start_r),
		.target_i    (target_r),
		.busy_o      (conv_busy),
		.done_o      (conv_done),
		.code_o      (conv_code)
	);

	// Register bus slave, one wait cycle per access
	wire        avs_req;
	wire        avs_take;
	reg  [31:0] rd_nxt;

	assign avs_req  = avs_read_i | avs_write_i;
	assign avs_take = avs_req & ~avs_waitrequest_o;

	always @* begin
		rd_nxt = 32'h00000000;
		if (avs_address_i == `SADC_OFF_CTRL) begin
			rd_nxt[`SADC_CTRL_EN_BIT] = ctrl_en_r;
		end else if (avs_address_i == `SADC_OFF_STATUS) begin
			rd_nxt[9:0]                = result_r;
			rd_nxt[`SADC_ST_BUSY_BIT]  = conv_busy;
			rd_nxt[`SADC_ST_FRAME_BIT] = (state_r == ST_XFER);
			rd_nxt[`SADC_ST_SMPL_BIT]  = sampling_o;
			rd_nxt[`SADC_ST_VALID_BIT] = valid_r;
		end else if (avs_address_i == `SADC_OFF_CONFIG) begin
			rd_nxt[7:0] = cfg_last_r;
		end else if (avs_address_i == `SADC_OFF_COUNT) begin
			rd_nxt[15:0] = conv_count_r;
		end else begin
			rd_nxt = 32'h00000000;
		end
	end

	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
			ctrl_en_r         <= `SADC_CTRL_RST;
		end else begin
			if (avs_req && avs_waitrequest_o) begin
				avs_waitrequest_o <= 1'b0;
				if (avs_read_i) begin
					avs_readdata_o <= rd_nxt;
				end
			end else begin
				avs_waitrequest_o <= 1'b1;
			end
			if (avs_take && avs_write_i &&
				avs_address_i == `SADC_OFF_CTRL) begin
				ctrl_en_r <= avs_writedata_i[`SADC_CTRL_EN_BIT];
			end
		end
	end

endmodule

`default_nettype wire

// >>> sim/sadc_host_model.sv
`default_nettype none
module sadc_host_model (
	input  wire logic ref_clk_i,
	input  wire logic dout_i,
	input  wire logic dout_oe_i,
	output var logic  cs_n_o,
	output var logic  sclk_o,
	output var logic  din_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic idle_r = 1'b1;
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o = 1'b0;
	end
	// Released data line toggles
	always @(posedge ref_clk_i) begin
		if (idle_r)
			din_o <= ~din_o;
	end
	task automatic run_frame(input logic [7:0] cfg, input int nclk,
		output logic [15:0] rx, output logic oe);
		rx = 16'h0;
		oe = 1'b0;
		idle_r <= 1'b0;
		cs_n_o <= 1'b0;
		repeat (40) @(posedge ref_clk_i);
		din_o <= cfg[7];
		for (int i = 0; i < nclk; i++) begin
			repeat (4) @(posedge ref_clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge ref_clk_i);
			rx[15 - i] = dout_i;
			oe = oe | dout_oe_i;
			sclk_o <= 1'b0;
			din_o <= (i < 7) ? cfg[6 - i] : ~din_o;
		end
		repeat (4) @(posedge ref_clk_i);
		cs_n_o <= 1'b1;
		idle_r <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> sim/sadc_top_asserts.sv
`default_nettype none
module sadc_top_asserts (
	input wire logic        ref_clk_i,
	input wire logic        reset_n_i,
	input wire logic [3:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        cs_n_i,
	input wire logic        sclk_i,
	input wire logic        dout_o,
	input wire logic        dout_oe_o,
	input wire logic        sampling_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sclk_q_r;
	logic [3:0] fall_age_r;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Cycles since shift clock fell
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_q_r <= 1'b0;
			fall_age_r <= 4'hf;
		end else begin
			sclk_q_r <= sclk_i;
			if (sclk_q_r && !sclk_i)
				fall_age_r <= 4'h0;
			else if (fall_age_r != 4'hf)
				fall_age_r <= fall_age_r + 4'h1;
		end
	end
	a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait pulse");
	a_bus_answer: assert property ($rose(avs_read_i) || $rose(avs_write_i)
		|-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bus answer");
	a_rd_unmapped: assert property (avs_read_i && avs_address_i == 4'h2
		&& !avs_waitrequest_o |-> avs_readdata_o == 32'h0) else $error("unmapped");
	a_noise_wait: assert property ($fell(cs_n_i) |-> !dout_oe_o [*8])
		else $error("early enable");
	a_oe_release: assert property ($rose(cs_n_i) |-> ##[1:5] !dout_oe_o)
		else $error("no release");
	a_oe_in_frame: assert property ($rose(dout_oe_o) |-> !$past(cs_n_i, 3))
		else $error("enable outside frame");
	a_dout_idle: assert property (!dout_oe_o |-> !dout_o)
		else $error("idle dout");
	a_dout_moves: assert property (dout_oe_o && $past(dout_oe_o)
		&& $changed(dout_o) |-> fall_age_r <= 4'h5) else $error("dout moved");
	a_smpl_width: assert property ($rose(sampling_o)
		|-> ##38 sampling_o ##[1:4] !sampling_o) else $error("sample width");
	a_smpl_select: assert property ($rose(sampling_o) |-> !cs_n_i)
		else $error("sample outside frame");
endmodule
bind sadc_top sadc_top_asserts i_sadc_top_asserts (
	.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .cs_n_i(cs_n_i),
	.sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
	.sampling_o(sampling_o)
);
`default_nettype wire

// >>> sim/tb_sadc_top.sv
`default_nettype none
module tb_sadc_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk_i = 1'b0;
	logic        reset_n_i;
	logic [3:0]  avs_address_i;
	logic        avs_read_i;
	logic        avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        cs_n_i;
	logic        sclk_i;
	logic        din_i;
	logic        aclk_i = 1'b0;
	logic        dout_o;
	logic        dout_oe_o;
	logic        sampling_o;
	logic [79:0] ain_i = {10'h3ff, 10'h050, 10'h155, 10'h0f0,
		10'h1c0, 10'h100, 10'h013, 10'h2a5};
	int          miscompares = 0;
	int          samples_checked = 0;
	int          aclk_cnt = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		aclk_cnt <= (aclk_cnt == 4) ? 0 : aclk_cnt + 1;
		if (aclk_cnt == 4)
			aclk_i <= ~aclk_i;
	end
	sadc_top i_sadc_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.cs_n_i(cs_n_i), .sclk_i(sclk_i), .din_i(din_i), .aclk_i(aclk_i),
		.ain_i(ain_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
		.sampling_o(sampling_o));
	sadc_host_model i_sadc_host_model (.ref_clk_i(ref_clk_i),
		.dout_i(dout_o), .dout_oe_i(dout_oe_o), .cs_n_o(cs_n_i),
		.sclk_o(sclk_i), .din_o(din_i));
	task automatic wrap_up;
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_read_i <= !wr;
		avs_write_i <= wr;
		do begin
			@(posedge ref_clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	function automatic logic [9:0] exp_code(input logic [7:0] c);
		int p;
		int n;
		int d;
		p = ain_i[c[6:4] * 10 +: 10];
		n = c[7] ? 0 : ain_i[(c[6:4] ^ 3'h1) * 10 +: 10];
		d = p - n;
		if (c[3])
			d = (d < 0) ? 0 : d;
		else
			d = (d < -512) ? -512 : ((d > 511) ? 511 : d);
		return d[9:0];
	endfunction
	function automatic logic [15:0] exp_word(input logic [7:0] c, logic [9:0] v);
		logic [15:0] w;
		int len;
		w = 16'h0;
		len = (c[1:0] == 2'h3) ? 16 : 8 + 2 * c[1:0];
		for (int i = 0; i < 10; i++)
			if (i < len)
				w[15 - i] = c[2] ? v[9 - i] : v[i];
		return w;
	endfunction
	task automatic t_regs;
		logic [31:0] d;
		bus(0, 4'h0, 0, d);
		chk("ctrl", 32'h1, d);
		bus(0, 4'hc, 0, d);
		chk("count", 32'h0, d);
		bus(0, 4'h2, 0, d);
		chk("unmapped", 32'h0, d);
	endtask
	task automatic t_modes;
		logic [7:0] cfg [8] = '{8'h8d, 8'hdb, 8'h26, 8'h30, 8'h15, 8'hf7,
			8'h6d, 8'h8d};
		logic [7:0] pc = 8'h0;
		logic [9:0] pv = 10'h0;
		logic [15:0] rx;
		logic oe;
		logic [31:0] d;
		for (int k = 0; k < 8; k++) begin
			i_sadc_host_model.run_frame(cfg[k], 16, rx, oe);
			chk("word", exp_word(pc, pv), rx);
			chk("enable", 32'h1, oe);
			repeat (600) @(posedge ref_clk_i);
			bus(0, 4'h4, 0, d);
			chk("status", {12'h0, 4'h8, 6'h0, exp_code(cfg[k])},
				d & 32'h000f03ff);
			bus(0, 4'hc, 0, d);
			chk("count", k + 1, d);
			bus(0, 4'h8, 0, d);
			chk("config", cfg[k], d);
			pc = cfg[k];
			pv = exp_code(cfg[k]);
		end
	endtask
	task automatic t_stops;
		logic [15:0] rx;
		logic oe;
		logic [31:0] d;
		bus(1, 4'h0, 0, d);
		i_sadc_host_model.run_frame(8'hdb, 16, rx, oe);
		chk("enable", 32'h0, oe);
		bus(1, 4'h0, 1, d);
		i_sadc_host_model.run_frame(8'hdb, 3, rx, oe);
		repeat (600) @(posedge ref_clk_i);
		bus(0, 4'hc, 0, d);
		chk("count", 32'h8, d);
		i_sadc_host_model.run_frame(8'hdb, 16, rx, oe);
		chk("word", exp_word(8'h8d, exp_code(8'h8d)), rx);
	endtask
	initial begin
		repeat (30000) @(posedge ref_clk_i);
		miscompares++;
		wrap_up;
	end
	initial begin
		reset_n_i = 1'b0;
		avs_address_i = 4'h0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		repeat (6) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_regs;
		t_modes;
		t_stops;
		wrap_up;
	end
endmodule
`default_nettype wire
